// ==== inc/bpu_pkg.sv ====
// bpu_pkg: shared constants and carriers for the branch prediction unit
// assumes one core clock; pipeline stages supply decoded instruction info
package bpu_pkg;
  localparam int ADDR_W = 32;
  localparam int BTB_IDX_W = 4;
  localparam int BTB_ENTRIES = 16;
  localparam int BTB_TAG_W = ADDR_W - BTB_IDX_W - 2;
  localparam int IDX_LSB = 2;
  localparam int RS_DEPTH = 4;
  localparam int RS_PTR_W = 2;
  localparam int RS_CNT_W = 3;
  localparam logic [1:0] HIST_STRONG_TAKEN = 2'h3;
  localparam logic [1:0] HIST_WEAK_TAKEN = 2'h2;
  localparam logic [1:0] HIST_WEAK_NOT = 2'h1;
  localparam logic [1:0] HIST_STRONG_NOT = 2'h0;
  localparam logic [1:0] PC_LOW_ALIGNED = 2'h0;
  localparam logic [1:0] PC_LOW_HALF = 2'h2;
  localparam logic PRED_EN_RESET = 1'b1;
  localparam logic RS_EN_RESET = 1'b1;
  localparam logic [RS_CNT_W-1:0] RS_CNT_RESET = 3'h0;

  // kind of change-of-flow seen by a stage
  typedef enum logic [3:0] {
    BPU_INS_OTHER = 4'h0,
    BPU_INS_BR_K8 = 4'h1,
    BPU_INS_BR_K21 = 4'h2,
    BPU_INS_JMP_K10 = 4'h3,
    BPU_INS_JMP_K21 = 4'h4,
    BPU_INS_CALL_K10 = 4'h5,
    BPU_INS_CALL_K21 = 4'h6,
    BPU_INS_BC_IF = 4'h7,
    BPU_INS_BC_IFCMP = 4'h8,
    BPU_INS_CALL_OTHER = 4'h9,
    BPU_INS_RET_MOVPC = 4'ha,
    BPU_INS_RET_AL = 4'hb,
    BPU_INS_RET_COND = 4'hc,
    BPU_INS_RET_POPM = 4'hd,
    BPU_INS_RET_LDM = 4'he
  } bpu_ins_e;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] pc;
    logic ext;
    bpu_ins_e kind;
  } bpu_ins_s;

  typedef struct packed {
    logic valid;
    logic [BTB_TAG_W-1:0] tag;
    logic ext;
    logic [1:0] hist;
    logic [ADDR_W-1:0] target;
  } bpu_btb_entry_s;

  typedef struct packed {
    logic hit;
    logic taken;
    logic ext;
    logic [ADDR_W-1:0] target;
  } bpu_pred_s;
endpackage

// ==== hw/bpu_hist_ctr.sv ====
// bpu_hist_ctr: next value of a 2-bit saturating history counter
// assumes the caller stores the result; purely combinational
`timescale 1ns/100ps
module bpu_hist_ctr (
  // current state and outcome
  input wire logic [1:0] hist_in,
  input wire logic taken_in,
  // next state and prediction
  output logic [1:0] hist_out,
  output logic pred_taken_out
);
  always_comb begin
    hist_out = hist_in; // see RULE_12
    if (taken_in && hist_in != bpu_pkg::HIST_STRONG_TAKEN) begin
      hist_out = hist_in + 2'h1;
    end else if (!taken_in && hist_in != bpu_pkg::HIST_STRONG_NOT) begin
      hist_out = hist_in - 2'h1;
    end
  end
  assign pred_taken_out = hist_in[1]; // see RULE_12
endmodule

// ==== hw/bpu_core.sv ====
// bpu_core: instruction forwarding, target buffer and return stack
// assumes fetch, decode and first execute stages give decoded info
// Behaviour
// RULE_01: forward to decode when queue empty, pc 00
// RULE_02: pc low 10 goes through queue
// RULE_03: forwarding only in native mode
// RULE_04: fetch predicted path, flush on mispredict
// RULE_05: hit branch folds into following instruction
// RULE_06: prediction only while enable bit set
// RULE_07: software invalidates buffer before enable change
// RULE_08: listed relative and bytecode branches predictable
// RULE_09: no folding of predictables, calls fold nothing
// RULE_10: direct mapped, indexed by address bits
// RULE_11: new entry strong taken and valid
// RULE_12: counter saturates, upper bit predicts taken
// RULE_13: history updated on every execution
// RULE_14: allocate on taken, absent, enabled, executed
// RULE_15: after reset enabled and buffer empty
// RULE_16: invalidate on reset, icache, address_space_identifier, bit
// RULE_17: address_space_identifier write does not flush pipeline
// RULE_18: four-entry circular stack, push on call
// RULE_19: taken return pops in decode, else first_execute
// RULE_20: saturating count, empty pop costs cycle
// RULE_21: static return prediction by opcode
// RULE_22: clearing stack enable empties stack
// RULE_23: after reset stack enabled and empty
`timescale 1ns/100ps
module bpu_core (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // fetch path
  input wire logic queue_empty_in,
  input wire logic fetch_valid_in,
  input wire logic [bpu_pkg::ADDR_W-1:0] fetch_pc_in,
  input wire logic bytecode_mode_in,
  output logic forward_out,
  output bpu_pkg::bpu_pred_s fetch_pred_out,
  // decode stage
  input bpu_pkg::bpu_ins_s decode_ins_in,
  input wire logic decode_next_foldable_in,
  input wire logic [bpu_pkg::ADDR_W-1:0] issue_pc_in,
  output logic fold_out,
  output logic ret_redirect_out,
  output logic [bpu_pkg::ADDR_W-1:0] ret_target_out,
  output logic ret_penalty_out,
  // first execute stage
  input bpu_pkg::bpu_ins_s exec_ins_in,
  input wire logic exec_leave_in,
  input wire logic exec_taken_in,
  input wire logic exec_predicted_in,
  input wire logic exec_pred_taken_in,
  input wire logic [bpu_pkg::ADDR_W-1:0] exec_target_in,
  input wire logic [bpu_pkg::ADDR_W-1:0] exec_next_pc_in,
  output logic flush_out,
  output logic [bpu_pkg::ADDR_W-1:0] resume_pc_out,
  // control bits
  input wire logic ctrl_wr_in,
  input wire logic pred_en_wdata_in,
  input wire logic pred_inv_wdata_in,
  input wire logic rs_en_wdata_in,
  input wire logic rs_flush_in,
  input wire logic icache_inv_in,
  input wire logic address_space_identifier_wr_in,
  output logic pred_en_out,
  output logic rs_en_out,
  output logic [bpu_pkg::RS_CNT_W-1:0] rs_count_out
);
  localparam int N = bpu_pkg::BTB_ENTRIES;
  localparam int IW = bpu_pkg::BTB_IDX_W;
  localparam int TW = bpu_pkg::BTB_TAG_W;
  localparam int LSB = bpu_pkg::IDX_LSB;

  logic pred_en_reg;
  logic rs_en_reg;
  logic [N-1:0] btb_valid_reg;
  logic [TW-1:0] btb_tag_reg [N];
  logic btb_ext_reg [N];
  logic [1:0] btb_hist_reg [N];
  logic [bpu_pkg::ADDR_W-1:0] btb_tgt_reg [N];
  logic [bpu_pkg::ADDR_W-1:0] rs_mem_reg [bpu_pkg::RS_DEPTH];
  logic [bpu_pkg::RS_PTR_W-1:0] rs_top_reg;
  logic [bpu_pkg::RS_CNT_W-1:0] rs_cnt_reg;
  logic [IW-1:0] f_idx, e_idx, d_idx;
  logic [TW-1:0] f_tag, e_tag;
  logic f_hit, e_hit, e_predictable, e_call, e_alloc, e_upd, btb_inv;
  logic [1:0] e_hist_next;
  logic f_pred_taken, e_mispredict, d_ret_taken, e_ret_pop, push, pop;
  logic dec_predictable, d_hit;

  function automatic logic is_predictable(bpu_pkg::bpu_ins_e k);
    // see RULE_08
    is_predictable = (k == bpu_pkg::BPU_INS_BR_K8) ||
      (k == bpu_pkg::BPU_INS_BR_K21) || (k == bpu_pkg::BPU_INS_JMP_K10) ||
      (k == bpu_pkg::BPU_INS_JMP_K21) || (k == bpu_pkg::BPU_INS_CALL_K10) ||
      (k == bpu_pkg::BPU_INS_CALL_K21) || (k == bpu_pkg::BPU_INS_BC_IF) ||
      (k == bpu_pkg::BPU_INS_BC_IFCMP);
  endfunction

  function automatic logic is_call(bpu_pkg::bpu_ins_e k);
    is_call = (k == bpu_pkg::BPU_INS_CALL_K10) ||
      (k == bpu_pkg::BPU_INS_CALL_K21) || (k == bpu_pkg::BPU_INS_CALL_OTHER);
  endfunction

  // forwarding past the queue
  assign forward_out = fetch_valid_in && queue_empty_in &&
    !bytecode_mode_in && // see RULE_03
    (fetch_pc_in[1:0] == bpu_pkg::PC_LOW_ALIGNED); // see RULE_01, RULE_02

  // lookup at fetch: index from pc bits above the word offset
  assign f_idx = fetch_pc_in[IW+LSB-1:LSB]; // see RULE_10
  assign f_tag = fetch_pc_in[bpu_pkg::ADDR_W-1:IW+LSB];
  assign f_hit = pred_en_reg && btb_valid_reg[f_idx] &&
    (btb_tag_reg[f_idx] == f_tag); // see RULE_06
  assign f_pred_taken = btb_hist_reg[f_idx][1];
  always_comb begin
    fetch_pred_out.hit = f_hit;
    fetch_pred_out.taken = f_hit && f_pred_taken; // see RULE_04
    fetch_pred_out.ext = btb_ext_reg[f_idx];
    fetch_pred_out.target = btb_tgt_reg[f_idx];
  end

  // folding needs the branch's entry present at decode
  assign d_idx = decode_ins_in.pc[IW+LSB-1:LSB];
  assign d_hit = btb_valid_reg[d_idx] &&
    (btb_tag_reg[d_idx] == decode_ins_in.pc[bpu_pkg::ADDR_W-1:IW+LSB]);
  // predictables never fold in, calls never absorb
  assign dec_predictable = is_predictable(decode_ins_in.kind);
  assign fold_out = decode_ins_in.valid && pred_en_reg && dec_predictable &&
    d_hit &&
    !is_call(decode_ins_in.kind) && decode_next_foldable_in &&
    (decode_ins_in.kind != bpu_pkg::BPU_INS_BC_IF) &&
    (decode_ins_in.kind != bpu_pkg::BPU_INS_BC_IFCMP); // see RULE_05, RULE_09

  // execute-side lookup for update and allocation
  assign e_idx = exec_ins_in.pc[IW+LSB-1:LSB];
  assign e_tag = exec_ins_in.pc[bpu_pkg::ADDR_W-1:IW+LSB];
  assign e_hit = btb_valid_reg[e_idx] && (btb_tag_reg[e_idx] == e_tag);
  assign e_predictable = exec_ins_in.valid && exec_leave_in &&
    is_predictable(exec_ins_in.kind);
  assign e_call = exec_ins_in.valid && exec_leave_in &&
    is_call(exec_ins_in.kind);
  assign e_upd = e_predictable && e_hit && pred_en_reg; // see RULE_13
  assign e_alloc = e_predictable && exec_taken_in && !e_hit &&
    pred_en_reg; // see RULE_14
  assign btb_inv = icache_inv_in || address_space_identifier_wr_in ||
    (ctrl_wr_in && pred_inv_wdata_in); // see RULE_16, RULE_17

  bpu_hist_ctr u_hist (
    .hist_in(btb_hist_reg[e_idx]),
    .taken_in(exec_taken_in),
    .hist_out(e_hist_next),
    .pred_taken_out()
  );

  // mispredict: flush and resume on the real path
  assign e_mispredict = exec_ins_in.valid && exec_leave_in &&
    exec_predicted_in && (exec_pred_taken_in != exec_taken_in);
  assign flush_out = e_mispredict; // see RULE_04, RULE_05
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resume_pc_out <= '0;
    end else if (e_mispredict) begin
      resume_pc_out <= exec_taken_in ? exec_target_in : exec_next_pc_in;
    end
  end

  // control bits
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pred_en_reg <= bpu_pkg::PRED_EN_RESET; // see RULE_15
      rs_en_reg <= bpu_pkg::RS_EN_RESET; // see RULE_23
    end else if (ctrl_wr_in) begin
      pred_en_reg <= pred_en_wdata_in; // see RULE_06
      rs_en_reg <= rs_en_wdata_in;
    end
  end
  assign pred_en_out = pred_en_reg;
  assign rs_en_out = rs_en_reg;

  // valid bits: invalidate wins over a same-cycle allocation
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      btb_valid_reg <= '0; // see RULE_15, RULE_16
    end else if (btb_inv) begin
      btb_valid_reg <= '0;
    end else if (e_alloc) begin
      btb_valid_reg[e_idx] <= 1'b1; // see RULE_11
    end
  end

  // entry payload needs no reset; guarded by valid
  always_ff @(posedge clk_sys_in) begin
    if (e_alloc && !btb_inv) begin
      btb_tag_reg[e_idx] <= e_tag;
      btb_ext_reg[e_idx] <= exec_ins_in.ext;
      btb_hist_reg[e_idx] <= bpu_pkg::HIST_STRONG_TAKEN; // see RULE_11
      btb_tgt_reg[e_idx] <= exec_target_in;
    end else if (e_upd) begin
      btb_hist_reg[e_idx] <= e_hist_next; // see RULE_12, RULE_13
    end
  end

  // return stack
  assign d_ret_taken = decode_ins_in.valid && rs_en_reg &&
    ((decode_ins_in.kind == bpu_pkg::BPU_INS_RET_MOVPC) ||
     (decode_ins_in.kind == bpu_pkg::BPU_INS_RET_AL) ||
     (decode_ins_in.kind == bpu_pkg::BPU_INS_RET_POPM) ||
     (decode_ins_in.kind == bpu_pkg::BPU_INS_RET_LDM)); // see RULE_21
  assign e_ret_pop = exec_ins_in.valid && exec_leave_in && rs_en_reg &&
    (exec_ins_in.kind == bpu_pkg::BPU_INS_RET_COND) &&
    exec_taken_in; // see RULE_19
  assign push = e_call && rs_en_reg; // see RULE_18
  assign pop = (d_ret_taken || e_ret_pop) &&
    (rs_cnt_reg != bpu_pkg::RS_CNT_RESET);
  assign ret_redirect_out = d_ret_taken &&
    (rs_cnt_reg != bpu_pkg::RS_CNT_RESET); // see RULE_19
  assign ret_penalty_out = d_ret_taken &&
    (rs_cnt_reg == bpu_pkg::RS_CNT_RESET); // see RULE_20
  assign ret_target_out = rs_mem_reg[rs_top_reg];
  assign rs_count_out = rs_cnt_reg;

  // push and pop together: replace top, counter unchanged
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rs_top_reg <= '0;
      rs_cnt_reg <= bpu_pkg::RS_CNT_RESET; // see RULE_23
    end else if (!rs_en_reg || rs_flush_in) begin
      rs_top_reg <= '0;
      rs_cnt_reg <= bpu_pkg::RS_CNT_RESET; // see RULE_22
    end else if (push && !pop) begin
      rs_top_reg <= rs_top_reg + 2'h1; // see RULE_18
      if (rs_cnt_reg != 3'(bpu_pkg::RS_DEPTH)) begin
        rs_cnt_reg <= rs_cnt_reg + 3'h1; // see RULE_20
      end
    end else if (pop && !push) begin
      rs_top_reg <= rs_top_reg - 2'h1;
      rs_cnt_reg <= rs_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rs_en_reg && !rs_flush_in && push) begin
      if (pop) begin
        rs_mem_reg[rs_top_reg] <= issue_pc_in;
      end else begin
        rs_mem_reg[rs_top_reg + 2'h1] <= issue_pc_in;
      end
    end
  end

  // checks
  chk_fwd_align: assert property ( // see RULE_01
    @(posedge clk_sys_in) disable iff (!nrst_in)
    forward_out |-> fetch_pc_in[1:0] == 2'h0 && !bytecode_mode_in)
    else $error("forwarded unaligned or bytecode fetch");
  chk_half_queue: assert property ( // see RULE_02
    @(posedge clk_sys_in) disable iff (!nrst_in)
    fetch_pc_in[1:0] == 2'h2 |-> !forward_out)
    else $error("halfword fetch forwarded");
  chk_pred_off: assert property ( // see RULE_06
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !pred_en_reg |-> !fetch_pred_out.hit)
    else $error("hit while prediction disabled");
  chk_fold_kind: assert property ( // see RULE_09
    @(posedge clk_sys_in) disable iff (!nrst_in)
    fold_out |-> !is_call(decode_ins_in.kind))
    else $error("call folded");
  chk_fold_hit: assert property ( // see RULE_05
    @(posedge clk_sys_in) disable iff (!nrst_in)
    fold_out |-> d_hit)
    else $error("fold without buffer entry");
  chk_flush_resume: assert property ( // see RULE_04
    @(posedge clk_sys_in) disable iff (!nrst_in)
    flush_out |=> resume_pc_out == ($past(exec_taken_in) ?
      $past(exec_target_in) : $past(exec_next_pc_in)))
    else $error("resume address not on real path");
  chk_alloc_valid: assert property ( // see RULE_11
    @(posedge clk_sys_in) disable iff (!nrst_in)
    e_alloc && !btb_inv |=> btb_valid_reg[$past(e_idx)] &&
      btb_hist_reg[$past(e_idx)] == bpu_pkg::HIST_STRONG_TAKEN)
    else $error("allocation not strong taken");
  chk_inv_clear: assert property ( // see RULE_16
    @(posedge clk_sys_in) disable iff (!nrst_in)
    btb_inv |=> btb_valid_reg == '0)
    else $error("buffer not invalidated");
  chk_alloc_cond: assert property ( // see RULE_14
    @(posedge clk_sys_in) disable iff (!nrst_in)
    e_alloc |-> exec_taken_in && pred_en_reg && !e_hit)
    else $error("bad allocation");
  // a flush in the same cycle empties the stack instead
  sequence s_push_full;
    push && !pop && !rs_flush_in && rs_cnt_reg == 3'h4;
  endsequence
  chk_rs_sat: assert property ( // see RULE_20
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_push_full ##1 rs_en_reg |-> rs_cnt_reg == 3'h4)
    else $error("stack counter not saturating");
  chk_rs_push: assert property ( // see RULE_18
    @(posedge clk_sys_in) disable iff (!nrst_in)
    push && !pop && !rs_flush_in && rs_cnt_reg < 3'h4 |=>
      rs_cnt_reg == $past(rs_cnt_reg) + 3'h1)
    else $error("call did not push");
  chk_ret_pop: assert property ( // see RULE_19
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ret_redirect_out && !push && !rs_flush_in |=>
      rs_cnt_reg == $past(rs_cnt_reg) - 3'h1)
    else $error("taken return did not pop");
  chk_rs_dis: assert property ( // see RULE_22
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !rs_en_reg |=> rs_cnt_reg == 3'h0)
    else $error("stack not emptied when disabled");
  chk_ret_cond: assert property ( // see RULE_21
    @(posedge clk_sys_in) disable iff (!nrst_in)
    decode_ins_in.kind == bpu_pkg::BPU_INS_RET_COND |-> !ret_redirect_out)
    else $error("conditional return popped in decode");
endmodule

// ==== bench/bpu_pipe_model.sv ====
// bpu_pipe_model: decode, issue and first execute stage stand-in
// assumes tasks are called just after a rising clock edge
`timescale 1ns/100ps
module bpu_pipe_model (
  // stage outputs towards the unit
  output bpu_pkg::bpu_ins_s dec_ins_out,
  output logic dec_fold_out,
  output logic [31:0] iss_pc_out,
  output bpu_pkg::bpu_ins_s ex_ins_out,
  output logic ex_leave_out,
  output logic ex_taken_out,
  output logic ex_pred_out,
  output logic ex_pred_tk_out,
  output logic [31:0] ex_tgt_out,
  output logic [31:0] ex_next_out
);
  initial begin
    dec_ins_out = '0;
    ex_ins_out = '0;
    {dec_fold_out, ex_leave_out, ex_taken_out} = 3'h0;
    {ex_pred_out, ex_pred_tk_out} = 2'h0;
    {iss_pc_out, ex_tgt_out, ex_next_out} = '0;
  end
  // released stages: pcs keep moving so stale values never match
  task automatic rel();
    dec_ins_out.valid <= 1'b0;
    dec_ins_out.pc <= ~dec_ins_out.pc;
    dec_fold_out <= 1'b0;
    ex_ins_out.valid <= 1'b0;
    ex_ins_out.pc <= ~ex_ins_out.pc;
    ex_leave_out <= 1'b0;
    ex_tgt_out <= ~ex_tgt_out;
  endtask
  // returns only by listed kinds; lv low models a stalled stage
  task automatic exe(input bpu_pkg::bpu_ins_e k, input logic [31:0] pc,
      input logic lv, tk, pr, prt, input logic [31:0] tgt);
    // long-offset kinds are the extended encodings
    ex_ins_out <= '{1'b1, pc, (k == bpu_pkg::BPU_INS_BR_K21) ||
      (k == bpu_pkg::BPU_INS_JMP_K21) || (k == bpu_pkg::BPU_INS_CALL_K21),
      k};
    ex_leave_out <= lv;
    ex_taken_out <= tk;
    ex_pred_out <= pr;
    ex_pred_tk_out <= prt;
    ex_tgt_out <= tgt;
    ex_next_out <= pc + 32'h4;
    iss_pc_out <= pc + 32'h4;
  endtask
  task automatic dec(input bpu_pkg::bpu_ins_e k, input logic [31:0] pc,
      input logic f);
    dec_ins_out <= '{1'b1, pc, 1'b0, k};
    dec_fold_out <= f;
  endtask
endmodule

// ==== bench/branch_prediction_unit_test.sv ====
// branch_prediction_unit_test: self-checking bench for bpu_core
// assumes bpu_pipe_model stands in for the pipeline stages
`timescale 1ns/100ps
module branch_prediction_unit_test;
  logic clk_sys_in, nrst_in, qe, fv, bc, wr, en, inv, rse, rsf, ic, address_space_identifier;
  logic [31:0] fpc, ret_tg, resume, iss_pc, ex_tg, ex_nx;
  logic fwd, fold, ret_rd, ret_pen, flush, pen, rsen;
  logic dfold, ex_lv, ex_tk, ex_pr, ex_prt;
  logic [2:0] rscnt;
  bpu_pkg::bpu_pred_s pred;
  bpu_pkg::bpu_ins_s dins, eins;
  int err_total = 0;
  int checks_done = 0;
  logic [8:0] oc = 9'b011110000;
  logic [8:0] ex = 9'b111100001;
  logic [6:0] ev [3] = '{7'b0101010, 7'b0101001, 7'b1111000};
  bpu_pkg::bpu_ins_e rk [4] = '{bpu_pkg::BPU_INS_RET_MOVPC,
    bpu_pkg::BPU_INS_RET_AL, bpu_pkg::BPU_INS_RET_POPM,
    bpu_pkg::BPU_INS_RET_LDM};
  bpu_core i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .queue_empty_in(qe), .fetch_valid_in(fv), .fetch_pc_in(fpc),
    .bytecode_mode_in(bc), .forward_out(fwd), .fetch_pred_out(pred),
    .decode_ins_in(dins), .decode_next_foldable_in(dfold),
    .issue_pc_in(iss_pc), .fold_out(fold), .ret_redirect_out(ret_rd),
    .ret_target_out(ret_tg), .ret_penalty_out(ret_pen),
    .exec_ins_in(eins), .exec_leave_in(ex_lv), .exec_taken_in(ex_tk),
    .exec_predicted_in(ex_pr), .exec_pred_taken_in(ex_prt),
    .exec_target_in(ex_tg), .exec_next_pc_in(ex_nx), .flush_out(flush),
    .resume_pc_out(resume), .ctrl_wr_in(wr), .pred_en_wdata_in(en),
    .pred_inv_wdata_in(inv), .rs_en_wdata_in(rse), .rs_flush_in(rsf),
    .icache_inv_in(ic), .address_space_identifier_wr_in(address_space_identifier), .pred_en_out(pen),
    .rs_en_out(rsen), .rs_count_out(rscnt));
  bpu_pipe_model i_pipe (.dec_ins_out(dins), .dec_fold_out(dfold),
    .iss_pc_out(iss_pc), .ex_ins_out(eins), .ex_leave_out(ex_lv),
    .ex_taken_out(ex_tk), .ex_pred_out(ex_pr), .ex_pred_tk_out(ex_prt),
    .ex_tgt_out(ex_tg), .ex_next_out(ex_nx));
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // release cycle: drops pulses and stages, then checks the lookup
  task automatic look(input logic [31:0] pc, input logic [1:0] ht,
      input logic [31:0] tgt);
    @(posedge clk_sys_in);
    fpc <= pc;
    {wr, rsf, ic, address_space_identifier} <= 4'h0;
    i_pipe.rel();
    @(negedge clk_sys_in);
    chk({pred.hit, pred.taken}, ht);
    if (ht[1]) chk(pred.target, tgt);
  endtask
  // v is {write, enable, invalidate, stack enable, stack flush, ic, address_space_identifier}
  task automatic ctl(input logic [6:0] v);
    @(posedge clk_sys_in);
    {wr, en, inv, rse, rsf, ic, address_space_identifier} <= v;
    @(negedge clk_sys_in);
  endtask
  task automatic run_ex(input bpu_pkg::bpu_ins_e k, input logic [31:0] pc,
      input logic lv, tk, pr, prt, input logic [31:0] tgt);
    @(posedge clk_sys_in);
    i_pipe.exe(k, pc, lv, tk, pr, prt, tgt);
    @(negedge clk_sys_in);
  endtask
  task automatic run_dec(input bpu_pkg::bpu_ins_e k, input logic f);
    @(posedge clk_sys_in);
    i_pipe.dec(k, 32'h700, f);
    @(negedge clk_sys_in);
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    err_total++;
    end_of_test();
  end
  initial begin
    {nrst_in, qe, fv, bc, wr, en, inv, rse, rsf, ic, address_space_identifier} = 11'h128;
    fpc = 32'h0;
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    look(32'h4, 2'b00, 0);
    chk({pen, rsen, rscnt}, 5'h18);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_in);
      qe <= i[0];
      fpc <= {30'h0, i[1], 1'b0};
      bc <= !i[2];
      @(negedge clk_sys_in);
      chk(fwd, i == 5);
    end
    for (int k = 1; k < 9; k++) begin
      run_ex(bpu_pkg::bpu_ins_e'(k), 32'(k) << 2, 1, 1, 0, 0, 32'h1000 + k);
      look(32'(k) << 2, 2'b11, 32'h1000 + k);
      chk(pred.ext, k == 2 || k == 4 || k == 6);
    end
    for (int j = 0; j < 3; j++) begin
      run_ex(j == 2 ? bpu_pkg::BPU_INS_OTHER : bpu_pkg::BPU_INS_BR_K8,
        32'h40, j != 0, j != 1, 0, 0, 32'h2000);
      look(32'h40, 2'b00, 0);
    end
    for (int i = 0; i < 9; i++) begin
      run_ex(bpu_pkg::BPU_INS_BR_K8, 32'h4, 1, oc[i], 0, 0, 32'h1001);
      look(32'h4, {1'b1, ex[i]}, 32'h1001);
    end
    look(32'h44, 2'b00, 0);
    run_ex(bpu_pkg::BPU_INS_BR_K8, 32'h44, 1, 1, 0, 0, 32'h3000);
    look(32'h44, 2'b11, 32'h3000);
    look(32'h4, 2'b00, 0);
    run_ex(bpu_pkg::BPU_INS_BR_K21, 32'h700, 1, 1, 0, 0, 32'h3100);
    look(32'h700, 2'b11, 32'h3100);
    run_dec(bpu_pkg::BPU_INS_BR_K21, 1);
    chk(fold, 1);
    look(32'h0, 2'b00, 0);
    run_dec(bpu_pkg::BPU_INS_CALL_K10, 1);
    chk(fold, 0);
    for (int j = 0; j < 3; j++) begin
      run_ex(bpu_pkg::BPU_INS_BR_K8, 32'h100, 1, j != 0, 1, j != 1, 32'h500);
      chk(flush, j != 2);
      look(32'h0, 2'b00, 0);
      if (j != 2) chk(resume, j ? 32'h500 : 32'h104);
    end
    for (int j = 0; j < 3; j++) begin
      run_ex(bpu_pkg::BPU_INS_BR_K8, 32'h200, 1, 1, 0, 0, 32'h600);
      look(32'h200, 2'b11, 32'h600);
      ctl(ev[j]);
      look(32'h200, 2'b00, 0);
    end
    ctl(7'b1011000);
    look(32'h0, 2'b00, 0);
    chk(pen, 0);
    run_ex(bpu_pkg::BPU_INS_BR_K8, 32'h200, 1, 1, 0, 0, 32'h600);
    look(32'h200, 2'b00, 0);
    ctl(7'b1111000);
    look(32'h0, 2'b00, 0);
    chk(pen, 1);
    for (int i = 0; i < 5; i++) begin
      run_ex(bpu_pkg::BPU_INS_CALL_OTHER, 32'h300 + i * 8, 1, 1, 1, 1, 0);
      look(32'h0, 2'b00, 0);
    end
    chk(rscnt, 4);
    for (int m = 0; m < 4; m++) begin
      run_dec(rk[m], 0);
      chk(ret_rd, 1);
      chk(ret_tg, 32'h324 - m * 8);
      look(32'h0, 2'b00, 0);
      chk(rscnt, 3 - m);
    end
    run_dec(bpu_pkg::BPU_INS_RET_AL, 0);
    chk({ret_rd, ret_pen}, 2'b01);
    run_ex(bpu_pkg::BPU_INS_CALL_K10, 32'h800, 1, 1, 1, 1, 0);
    look(32'h0, 2'b00, 0);
    run_dec(bpu_pkg::BPU_INS_RET_COND, 0);
    chk(ret_rd, 0);
    look(32'h0, 2'b00, 0);
    chk(rscnt, 1);
    run_ex(bpu_pkg::BPU_INS_RET_COND, 32'h700, 1, 1, 0, 0, 32'h804);
    look(32'h0, 2'b00, 0);
    chk(rscnt, 0);
    run_ex(bpu_pkg::BPU_INS_CALL_K21, 32'h900, 1, 1, 1, 1, 0);
    look(32'h0, 2'b00, 0);
    chk(rscnt, 1);
    ctl(7'b0000100);
    look(32'h0, 2'b00, 0);
    chk(rscnt, 0);
    run_ex(bpu_pkg::BPU_INS_CALL_K21, 32'h900, 1, 1, 1, 1, 0);
    look(32'h0, 2'b00, 0);
    ctl(7'b1100000);
    // counter clears on the edge after the enable bit drops
    look(32'h0, 2'b00, 0);
    look(32'h0, 2'b00, 0);
    chk({rsen, rscnt}, 4'h0);
    end_of_test();
  end
endmodule
